// ### bbs_bank.sv
// Buck-boost set-point register, voltage transition control and monitor blanking
`include "bbs_consts.svh"

module bbs_bank
    import bbs_pkg::*;
#(
    parameter int BLANK_CYCLES = `BBS_BLANK_CYCLES,
    parameter int STEP_CYCLES = `BBS_STEP_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    // Register port
    input wire logic wr_en,
    input wire logic rd_en,
    input wire bbs_pkg::bbs_byte_type addr,
    input wire bbs_pkg::bbs_byte_type wr_data,
    output bbs_pkg::bbs_byte_type rd_data,
    // Converters one and two
    input wire logic conv12_setpoint_update,
    input wire logic conv12_ramp_done,
    output logic conv12_ramp_start,
    output logic conv12_ramping,
    output logic conv12_step_tick,
    output logic conv12_immediate,
    output logic [2:0] slew_code,
    // Buck-boost converter
    output logic pulse_skip_enable,
    output logic [5:0] bb_setpoint,
    output logic monitor_blank
);
    import bbs_pkg::*;

    localparam int TW = 20;

    bbs_state_type state;
    bbs_state_type next_state;
    logic go_bit;
    logic trigger_bypass;
    logic next_go_bit;
    logic next_trigger_bypass;
    logic next_pulse_skip_enable;
    logic [5:0] next_bb_setpoint;
    logic [2:0] next_slew_code;
    logic next_ramp_start;
    bbs_byte_type next_rd_data;
    logic wr_setpt;
    logic wr_slew;
    logic go_write;
    logic start;
    logic step_expire;
    logic [TW-1:0] step_period;

    assign wr_setpt = wr_en && (addr == `BBS_ADDR_SETPT);
    assign wr_slew = wr_en && (addr == `BBS_ADDR_SLEW);
    assign go_write = wr_slew && wr_data[`BBS_BIT_GO];
    // Bypass lets an outside set-point change launch the ramp directly
    assign start = go_write || (trigger_bypass && conv12_setpoint_update);

    // Register contents
    always_comb begin
        next_pulse_skip_enable = pulse_skip_enable;
        next_bb_setpoint = bb_setpoint;
        next_slew_code = slew_code;
        next_trigger_bypass = trigger_bypass;
        if (wr_setpt) begin
            next_pulse_skip_enable = wr_data[`BBS_BIT_PSE];
            // Reserved codes would drive the converter out of range, so they are dropped
            if (wr_data[5:0] <= `BBS_SETPT_MAX) begin
                next_bb_setpoint = wr_data[5:0];
            end
        end
        if (wr_slew) begin
            next_trigger_bypass = wr_data[`BBS_BIT_BYPASS];
            next_slew_code = wr_data[2:0];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pulse_skip_enable <= 1'(`BBS_SETPT_RESET >> `BBS_BIT_PSE);
            bb_setpoint <= 6'(`BBS_SETPT_RESET);
            slew_code <= 3'(`BBS_SLEW_RESET);
            trigger_bypass <= 1'b0;
        end else if (ce) begin
            pulse_skip_enable <= next_pulse_skip_enable;
            bb_setpoint <= next_bb_setpoint;
            slew_code <= next_slew_code;
            trigger_bypass <= next_trigger_bypass;
        end
    end

    // Transition sequencer for converters one and two only
    always_comb begin
        next_state = state;
        next_go_bit = go_bit;
        next_ramp_start = 1'b0;
        case (state)
            BBS_IDLE: begin
                if (start) begin
                    next_state = BBS_RAMP;
                    next_ramp_start = 1'b1;
                end
            end
            BBS_RAMP: begin
                if (conv12_ramp_done) begin
                    next_state = BBS_IDLE;
                    next_go_bit = 1'b0;
                end
            end
            default: begin
                next_state = BBS_IDLE;
            end
        endcase
        // A new trigger in the finishing cycle wins over the self-clear
        if (start && (state == BBS_RAMP)) begin
            next_state = BBS_RAMP;
            next_ramp_start = 1'b1;
        end
        if (go_write) begin
            next_go_bit = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= BBS_IDLE;
            go_bit <= 1'b0;
            conv12_ramp_start <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            go_bit <= next_go_bit;
            conv12_ramp_start <= next_ramp_start;
        end
    end

    assign conv12_ramping = (state == BBS_RAMP);
    assign conv12_immediate = (slew_code == `BBS_SLEW_IMMEDIATE);
    assign step_period = TW'(STEP_CYCLES >> slew_code);
    assign conv12_step_tick = step_expire && conv12_ramping && !conv12_immediate;

    bbs_timer #(.W(TW)) u_step (
        .core_clk(core_clk),
        .nrst(nrst),
        .ce(ce),
        .load(conv12_ramp_start || (step_expire && conv12_ramping)),
        .period(step_period),
        .busy(),
        .expire(step_expire)
    );

    bbs_timer #(.W(TW)) u_blank (
        .core_clk(core_clk),
        .nrst(nrst),
        .ce(ce),
        .load(wr_setpt),
        .period(TW'(BLANK_CYCLES)),
        .busy(monitor_blank),
        .expire()
    );

    // Read data; reserved bits stay zero
    always_comb begin
        next_rd_data = rd_data;
        if (rd_en) begin
            case (addr)
                `BBS_ADDR_SETPT: next_rd_data = {pulse_skip_enable, 1'b0, bb_setpoint};
                `BBS_ADDR_SLEW: next_rd_data = {go_bit, trigger_bypass, 3'h0, slew_code};
                default: next_rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= 8'h00;
        end else if (ce) begin
            rd_data <= next_rd_data;
        end
    end

    // Checks
    sequence bbs_setpt_write_s;
        ce && wr_setpt;
    endsequence

    sequence bbs_blank_hold_s;
        monitor_blank [*4];
    endsequence

    AST_PSE_FOLLOWS_WRITE: assert property (@(posedge core_clk) disable iff (!nrst)
        bbs_setpt_write_s |=> pulse_skip_enable == $past(wr_data[7]))
        else $error("pulse skip enable did not follow write");

    AST_SETPT_IN_RANGE: assert property (@(posedge core_clk) disable iff (!nrst)
        (ce && wr_setpt && wr_data[5:0] > `BBS_SETPT_MAX) |=> $stable(bb_setpoint))
        else $error("reserved set-point code was stored");

    AST_GO_STARTS_RAMP: assert property (@(posedge core_clk) disable iff (!nrst)
        (ce && go_write) |=> go_bit && conv12_ramp_start && conv12_ramping)
        else $error("trigger write did not start ramp");

    AST_GO_SELF_CLEARS: assert property (@(posedge core_clk) disable iff (!nrst)
        (ce && conv12_ramping && conv12_ramp_done && !start) |=> !go_bit && !conv12_ramping)
        else $error("trigger bit not cleared at end of transition");

    AST_BYPASS_UPDATE: assert property (@(posedge core_clk) disable iff (!nrst)
        (ce && conv12_setpoint_update && !go_write) |=> conv12_ramp_start == $past(trigger_bypass))
        else $error("set-point update and bypass disagree");

    AST_BB_WRITE_NO_RAMP: assert property (@(posedge core_clk) disable iff (!nrst)
        (ce && wr_setpt && !conv12_setpoint_update) |=> !conv12_ramp_start)
        else $error("buck-boost write started a slewed ramp");

    AST_RESERVED_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
        (ce && rd_en && addr == `BBS_ADDR_SLEW) |=> rd_data[5:3] == 3'h0)
        else $error("reserved slew read bits not zero");

    AST_RESERVED_ZERO_SETPT: assert property (@(posedge core_clk) disable iff (!nrst)
        (ce && rd_en && addr == `BBS_ADDR_SETPT) |=> rd_data[6] == 1'b0)
        else $error("reserved set-point read bit not zero");

    AST_SLEW_WRITE: assert property (@(posedge core_clk) disable iff (!nrst)
        (ce && wr_slew) |=> slew_code == $past(wr_data[2:0]) && conv12_immediate == ($past(wr_data[2:0]) == 3'h7))
        else $error("slew code not stored");

    AST_BLANK_STARTS: assert property (@(posedge core_clk) disable iff (!nrst)
        bbs_setpt_write_s |=> bbs_blank_hold_s)
        else $error("monitor blanking did not start on set-point write");
endmodule

// ### bbs_consts.svh
// Offsets, field positions, reset values and timing counts of the buck-boost set-point and slew bank
`ifndef BBS_CONSTS_SVH
`define BBS_CONSTS_SVH
`define BBS_ADDR_SETPT 8'h19
`define BBS_ADDR_SLEW 8'h1a
`define BBS_SETPT_RESET 8'h94
`define BBS_SLEW_RESET 8'h06
`define BBS_BIT_PSE 7
`define BBS_BIT_GO 7
`define BBS_BIT_BYPASS 6
`define BBS_SETPT_MAX 6'h34
`define BBS_SLEW_IMMEDIATE 3'h7
`define BBS_CLK_MHZ 200
`define BBS_BLANK_TIME_US 5000
`define BBS_STEP_TIME_US 160
`define BBS_BLANK_CYCLES (`BBS_BLANK_TIME_US * `BBS_CLK_MHZ)
`define BBS_STEP_CYCLES (`BBS_STEP_TIME_US * `BBS_CLK_MHZ)
`endif

// ### bbs_pkg.sv
// Types of the buck-boost set-point and slew bank
package bbs_pkg;
    typedef enum logic [1:0] {
        BBS_IDLE = 2'b01,
        BBS_RAMP = 2'b10
    } bbs_state_type;
    typedef logic [7:0] bbs_byte_type;
endpackage

// ### bbs_timer.sv
// Reloadable down-counter with a one-cycle expiry pulse
module bbs_timer #(
    parameter int W = 20
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    // Control
    input wire logic load,
    input wire logic [W-1:0] period,
    // Status
    output logic busy,
    output logic expire
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (load) begin
            next_count = period;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
        end else if (ce) begin
            count <= next_count;
        end
    end

    assign busy = (count != '0);
    // Expiry ignores load, so a caller may reload from the pulse itself without a loop
    assign expire = ce && (count == {{(W-1){1'b0}}, 1'b1});
endmodule

// ### bbs_conv_model.sv
// Model of the converter one and two control loops that finish each ramp after a delay
module bbs_conv_model #(
    parameter int RAMP_CYCLES = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Ramp handshake
    input wire logic ramp_start,
    output logic ramp_done
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt;
    // A new start reloads the count, so an early restart never yields a stray done
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 0;
            ramp_done <= 1'b0;
        end else begin
            ramp_done <= (cnt == 1) && !ramp_start;
            if (ramp_start) begin
                // The host keeps pulse skipping off before any downward ramp, so each ramp ends in fixed time
                cnt <= RAMP_CYCLES;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

// ### testbench.sv
// Self-checking bench for the buck-boost set-point and slew bank
`include "bbs_consts.svh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import bbs_pkg::*;
    logic core_clk = 1'b0, nrst = 1'b0, ce = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
    bbs_byte_type addr = 8'h00, wr_data = 8'h00, rd_data, v;
    logic conv12_setpoint_update = 1'b0, conv12_ramp_done, conv12_ramp_start, conv12_ramping;
    logic conv12_step_tick, conv12_immediate, pulse_skip_enable, monitor_blank;
    logic [2:0] slew_code;
    logic [5:0] bb_setpoint;
    int failures = 0, n_tests = 0, cyc = 0;
    bbs_bank #(.BLANK_CYCLES(20), .STEP_CYCLES(64)) i_bbs_bank (.core_clk(core_clk), .nrst(nrst), .ce(ce),
        .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
        .conv12_setpoint_update(conv12_setpoint_update), .conv12_ramp_done(conv12_ramp_done),
        .conv12_ramp_start(conv12_ramp_start), .conv12_ramping(conv12_ramping),
        .conv12_step_tick(conv12_step_tick), .conv12_immediate(conv12_immediate), .slew_code(slew_code),
        .pulse_skip_enable(pulse_skip_enable), .bb_setpoint(bb_setpoint), .monitor_blank(monitor_blank));
    bbs_conv_model i_bbs_conv_model (.core_clk(core_clk), .nrst(nrst), .ramp_start(conv12_ramp_start),
        .ramp_done(conv12_ramp_done));
    always #2.5 core_clk = ~core_clk;
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Bounds a hang; the whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            final_report();
        end
    end
    task automatic chk(input string nm, input bbs_byte_type e, input bbs_byte_type g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input bbs_byte_type a, input bbs_byte_type d);
        @(posedge core_clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge core_clk);
        wr_en <= 1'b0;
        #1;
    endtask
    task automatic rd(input bbs_byte_type a, output bbs_byte_type d);
        @(posedge core_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic pulse_update();
        @(posedge core_clk);
        conv12_setpoint_update <= 1'b1;
        @(posedge core_clk);
        conv12_setpoint_update <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 50 && conv12_ramping !== 1'b0; i++) begin
            @(posedge core_clk);
            #1;
        end
        chk("ramping", 8'h00, {7'h0, conv12_ramping});
    endtask
    task automatic t_reset();
        rd(`BBS_ADDR_SETPT, v);
        chk("setpt reset", 8'h94, v);
        rd(`BBS_ADDR_SLEW, v);
        chk("slew reset", 8'h06, v);
        rd(8'h33, v);
        chk("unmapped", 8'h00, v);
        chk("bb_setpoint", 8'h14, {2'b0, bb_setpoint});
        $display("test reset done");
    endtask
    task automatic t_setpt();
        wr(`BBS_ADDR_SETPT, 8'hff);
        rd(`BBS_ADDR_SETPT, v);
        chk("reserved code", 8'h94, v);
        wr(`BBS_ADDR_SETPT, 8'h73);
        rd(`BBS_ADDR_SETPT, v);
        chk("setpt", 8'h33, v);
        chk("pse", 8'h00, {7'h0, pulse_skip_enable});
        chk("no ramp", 8'h00, {7'h0, conv12_ramping});
        chk("blank", 8'h01, {7'h0, monitor_blank});
        repeat (17) @(posedge core_clk);
        #1 chk("blank last", 8'h01, {7'h0, monitor_blank});
        @(posedge core_clk);
        #1 chk("blank end", 8'h00, {7'h0, monitor_blank});
        $display("test setpoint done");
    endtask
    task automatic t_go();
        wr(`BBS_ADDR_SLEW, 8'h3f);
        rd(`BBS_ADDR_SLEW, v);
        chk("slew", 8'h07, v);
        chk("immediate", 8'h01, {7'h0, conv12_immediate});
        chk("no go", 8'h00, {7'h0, conv12_ramping});
        chk("slew_code", 8'h07, {5'h0, slew_code});
        wr(`BBS_ADDR_SLEW, 8'h84);
        chk("ramp start", 8'h01, {7'h0, conv12_ramp_start});
        @(posedge core_clk);
        #1 chk("ramping", 8'h01, {7'h0, conv12_ramping});
        chk("no tick yet", 8'h00, {7'h0, conv12_step_tick});
        // Code 4 gives a step every 64 >> 4 = 4 cycles after the start pulse
        repeat (3) @(posedge core_clk);
        #1 chk("step tick", 8'h01, {7'h0, conv12_step_tick});
        rd(`BBS_ADDR_SLEW, v);
        chk("go set", 8'h84, v);
        wait_idle();
        rd(`BBS_ADDR_SLEW, v);
        chk("go clear", 8'h04, v);
        $display("test go done");
    endtask
    task automatic t_bypass();
        pulse_update();
        chk("no bypass", 8'h00, {7'h0, conv12_ramping});
        wr(`BBS_ADDR_SLEW, 8'h46);
        pulse_update();
        chk("bypass ramp", 8'h01, {7'h0, conv12_ramping});
        rd(`BBS_ADDR_SLEW, v);
        chk("bypass read", 8'h46, v);
        wait_idle();
        $display("test bypass done");
    endtask
    task automatic t_freeze();
        @(posedge core_clk);
        ce <= 1'b0;
        wr(`BBS_ADDR_SETPT, 8'h10);
        @(posedge core_clk);
        ce <= 1'b1;
        rd(`BBS_ADDR_SETPT, v);
        chk("frozen setpt", 8'h33, v);
        chk("frozen blank", 8'h00, {7'h0, monitor_blank});
        $display("test freeze done");
    endtask
    task automatic t_reset_again();
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        rd(`BBS_ADDR_SLEW, v);
        chk("slew reset again", 8'h06, v);
        rd(`BBS_ADDR_SETPT, v);
        chk("setpt reset again", 8'h94, v);
        $display("test reset again done");
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
        t_setpt();
        t_go();
        t_bypass();
        t_freeze();
        t_reset_again();
        final_report();
    end
endmodule
